// [rtl/crg_crc8_engine.sv]
// byte-serial crc-8 engine, one byte per clock, lowest byte first
// assumes start is a one-cycle pulse from the same clock domain
`timescale 1ns/1ns
`default_nettype none
module crg_crc8_engine (
  input  wire logic  ref_clk_i,
  input  wire logic  resetn_i,
  crg_crc_if.eng     crc_if
);
  import crg_pkg::*;

  logic [63:0] word_ff;
  logic [7:0]  crc_ff;
  logic [3:0]  cnt_ff;
  logic        done_ff;

  // one byte fed msb first through poly x^8+x^2+x+1
  function automatic logic [7:0] crc_byte(input logic [7:0] seed, input logic [7:0] data);
    logic [7:0] c;
    c = seed ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // snapshot word on start, so writes during the run cannot tear it
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      word_ff <= 64'h0000_0000_0000_0000;
      crc_ff  <= 8'h00;
      cnt_ff  <= 4'h0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (crc_if.start) begin
        word_ff <= crc_if.word;
        crc_ff  <= CRC_SEED;
        cnt_ff  <= 4'(BYTES_N);
      end else if (cnt_ff != 4'h0) begin
        crc_ff  <= crc_byte(crc_ff, word_ff[7:0]);
        word_ff <= word_ff >> 8;                         // lowest byte first
        cnt_ff  <= cnt_ff - 4'h1;
        done_ff <= (cnt_ff == 4'h1);
      end
    end
  end

  assign crc_if.crc  = crc_ff;
  assign crc_if.done = done_ff;
endmodule
`default_nettype wire

// [rtl/crg_crc_if.sv]
// start/result handshake between the guard and its crc engine
// assumes both ends sit on the same system clock
`timescale 1ns/1ns
`default_nettype none
interface crg_crc_if;
  logic        start;
  logic [63:0] word;
  logic        done;
  logic [7:0]  crc;

  modport ctl (output start, output word, input done, input crc);
  modport eng (input start, input word, output done, output crc);
endinterface
`default_nettype wire

// [rtl/crg_guard.sv]
// configuration register crc guard: write lock, cfg signature check, nvm check hooks
// assumes all control strobes come from an spi decoder on ref_clk_i, one cycle each
`timescale 1ns/1ns
`default_nettype none
module crg_guard #(
  parameter int unsigned NVM_TIMEOUT_CYCLES = crg_pkg::NVM_CRC_CYCLES
) (
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  // protected register write port and revision field input
  input  wire logic        prot_wr_i,
  input  wire logic [3:0]  prot_idx_i,
  input  wire logic [7:0]  prot_wdata_i,
  input  wire logic [7:0]  revision_i,
  // lock control
  input  wire logic        lock_set_i,
  input  wire logic        lock_clr_i,
  // stored signature and config check enable
  input  wire logic        sig_wr_i,
  input  wire logic [7:0]  sig_wdata_i,
  input  wire logic        cfg_en_wr_i,
  input  wire logic        cfg_en_wdata_i,
  // nvm check
  input  wire logic        nvm_trig_wr_i,
  input  wire logic        nvm_done_i,
  input  wire logic        nvm_good_i,
  output logic             nvm_start_o,
  output logic             nvm_check_trigger_o,
  output logic             nvm_error_flag_o,
  // operating state links
  input  wire logic        diag_state_i,
  input  wire logic        other_safe_entry_i,
  input  wire logic        safe_exit_i,
  input  wire logic        enable_drive_cmd_i,
  output logic             safe_req_o,
  output logic             enable_drive_out_o,
  output logic [3:0]       device_error_count_o,
  // status
  output logic             lock_o,
  output logic             cfg_check_en_o,
  output logic             cfg_busy_o,
  output logic             cfg_mismatch_o,
  output logic [7:0]       stored_sig_o,
  output logic [7:0]       calc_sig_o,
  output logic [63:0]      prot_word_o
);
  import crg_pkg::*;

  crg_crc_if crc_if ();

  logic [6:0]     function_config_reg_ff;
  logic [3:0]     powerdown_threshold_cfg_ff;
  logic [7:0]     error_cfg_ff;
  logic [7:0]     watchdog_token_feedback_ff;
  logic [4:0]     watchdog_window_b_cfg_ff;
  logic [6:0]     watchdog_window_a_cfg_ff;
  logic [7:0]     low_pulse_limit_ff;
  logic [7:0]     device_config_b_ff;
  logic [7:0]     device_config_a_ff;
  logic           lock_ff;
  logic [7:0]     sig_ff;
  logic           cfg_en_ff;
  crg_cfg_state_e cfg_state_ff;
  logic           mismatch_ff;
  logic [7:0]     calc_ff;
  logic           poison_ff;
  logic           nvm_trig_ff;
  logic           nvm_err_ff;
  logic [31:0]    nvm_cnt_ff;
  logic           safe_ff;
  logic           safe_req_ff;
  logic [3:0]     err_cnt_ff;
  logic           drive_ff;
  logic [63:0]    prot_word;
  logic           wr_ok;
  logic           en_rise;
  logic           en_fall;
  logic           cfg_done;
  logic           cfg_bad;
  logic           nvm_finish;
  logic           nvm_ok;
  logic           diag_trip;

  ////////////////////////////////////////////////////////////////////////////
  // protected word assembly
  always_comb begin
    prot_word = 64'h0000_0000_0000_0000;
    prot_word[POS_FUNC_CFG  +: 7] = function_config_reg_ff;
    prot_word[POS_REVISION  +: 8] = revision_i;
    prot_word[POS_PWD_THR   +: 4] = powerdown_threshold_cfg_ff;
    prot_word[POS_ERR_CFG   +: 8] = error_cfg_ff;
    prot_word[POS_TOKEN_FB  +: 8] = watchdog_token_feedback_ff;
    prot_word[POS_WIN_B     +: 5] = watchdog_window_b_cfg_ff;
    prot_word[POS_WIN_A     +: 7] = watchdog_window_a_cfg_ff;
    prot_word[POS_LOW_PULSE +: 8] = low_pulse_limit_ff;
    prot_word[POS_DEV_CFG_B +: 8] = device_config_b_ff;
    prot_word[POS_DEV_CFG_A]      = device_config_a_ff[DEV_CFG_A_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // write lock: set wins over a same-cycle clear
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lock_ff <= 1'b0;
    end else if (lock_set_i) begin
      lock_ff <= 1'b1;
    end else if (lock_clr_i) begin
      lock_ff <= 1'b0;
    end
  end

  assign wr_ok = prot_wr_i && !lock_ff;

  // protected registers, writes dropped while locked
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      function_config_reg_ff     <= RST_FUNC_CFG;
      powerdown_threshold_cfg_ff <= RST_PWD_THR;
      error_cfg_ff               <= RST_ERR_CFG;
      watchdog_token_feedback_ff <= RST_TOKEN_FB;
      watchdog_window_b_cfg_ff   <= RST_WIN_B;
      watchdog_window_a_cfg_ff   <= RST_WIN_A;
      low_pulse_limit_ff         <= RST_LOW_PULSE;
      device_config_b_ff         <= RST_DEV_CFG_B;
      device_config_a_ff         <= RST_DEV_CFG_A;
    end else if (wr_ok) begin
      if (prot_idx_i == IDX_FUNC_CFG) begin
        function_config_reg_ff <= prot_wdata_i[6:0];
      end else if (prot_idx_i == IDX_PWD_THR) begin
        powerdown_threshold_cfg_ff <= prot_wdata_i[3:0];
      end else if (prot_idx_i == IDX_ERR_CFG) begin
        error_cfg_ff <= prot_wdata_i;
      end else if (prot_idx_i == IDX_TOKEN_FB) begin
        watchdog_token_feedback_ff <= prot_wdata_i;
      end else if (prot_idx_i == IDX_WIN_B) begin
        watchdog_window_b_cfg_ff <= prot_wdata_i[4:0];
      end else if (prot_idx_i == IDX_WIN_A) begin
        watchdog_window_a_cfg_ff <= prot_wdata_i[6:0];
      end else if (prot_idx_i == IDX_LOW_PULSE) begin
        low_pulse_limit_ff <= prot_wdata_i;
      end else if (prot_idx_i == IDX_DEV_CFG_B) begin
        device_config_b_ff <= prot_wdata_i;
      end else if (prot_idx_i == IDX_DEV_CFG_A) begin
        device_config_a_ff <= prot_wdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stored signature; not lock protected so the host can always update it
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sig_ff <= RST_SIG;
    end else if (sig_wr_i) begin
      sig_ff <= sig_wdata_i;
    end
  end

  assign en_rise   = cfg_en_wr_i && cfg_en_wdata_i && !cfg_en_ff;
  assign en_fall   = cfg_en_wr_i && !cfg_en_wdata_i && cfg_en_ff;
  assign diag_trip = en_fall && mismatch_ff && diag_state_i;

  // config check enable bit
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_en_ff <= 1'b0;
    end else if (cfg_en_wr_i) begin
      cfg_en_ff <= cfg_en_wdata_i;                        // diag trip writes 0 anyway
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cfg check sequencer: 8 byte cycles plus 2, well inside the 2.1 us budget
  assign crc_if.start = en_rise;
  assign crc_if.word  = prot_word;
  assign cfg_done     = crc_if.done && (cfg_state_ff == CFG_RUN) && cfg_en_ff;
  assign cfg_bad      = cfg_done && (crc_if.crc != sig_ff);

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_state_ff <= CFG_IDLE;
    end else begin
      case (cfg_state_ff)
        CFG_IDLE: begin
          if (en_rise) begin
            cfg_state_ff <= CFG_RUN;
          end
        end
        CFG_RUN: begin
          if (crc_if.done) begin
            cfg_state_ff <= CFG_IDLE;
          end
        end
        default: begin
          cfg_state_ff <= CFG_IDLE;
        end
      endcase
    end
  end

  // last computed signature, for readback
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      calc_ff <= 8'h00;
    end else if (crc_if.done) begin
      calc_ff <= crc_if.crc;
    end
  end

  crg_crc8_engine u_crc (                                 // host recipe, reference vectors hold
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .crc_if    (crc_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // nvm check: finish on done from the nvm checker or on timeout as an error
  assign nvm_finish = nvm_trig_ff && (nvm_done_i || (nvm_cnt_ff == 32'(NVM_TIMEOUT_CYCLES)));
  assign nvm_ok     = nvm_finish && nvm_done_i && nvm_good_i && !poison_ff;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      nvm_trig_ff <= 1'b0;
      nvm_cnt_ff  <= 32'h0000_0000;
    end else if (nvm_trig_wr_i && !nvm_trig_ff) begin
      nvm_trig_ff <= 1'b1;
      nvm_cnt_ff  <= 32'h0000_0000;
    end else if (nvm_finish) begin
      nvm_trig_ff <= 1'b0;
    end else if (nvm_trig_ff) begin
      nvm_cnt_ff  <= nvm_cnt_ff + 32'h0000_0001;
    end
  end

  // start pulse to the nvm checker
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      nvm_start_o <= 1'b0;
    end else begin
      nvm_start_o <= nvm_trig_wr_i && !nvm_trig_ff;
    end
  end

  // pending mismatch left behind by clearing the enable
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      poison_ff <= 1'b0;
    end else if (en_fall && mismatch_ff) begin
      poison_ff <= 1'b1;
    end else if (nvm_finish) begin
      poison_ff <= 1'b0;
    end
  end

  // nvm error flag: set while running, by diag trip, or by a bad result
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      nvm_err_ff <= 1'b0;
    end else if (diag_trip || (nvm_trig_wr_i && !nvm_trig_ff)) begin
      nvm_err_ff <= 1'b1;
    end else if (nvm_finish) begin
      nvm_err_ff <= !nvm_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mismatch flag: a new mismatch wins over any same-cycle clear
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mismatch_ff <= 1'b0;
    end else if (cfg_bad) begin
      mismatch_ff <= 1'b1;
    end else if (cfg_done || nvm_ok) begin
      mismatch_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // safe state held here until the state controller reports the exit
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      safe_ff     <= 1'b0;
      safe_req_ff <= 1'b0;
    end else begin
      safe_req_ff <= diag_trip;
      if (diag_trip) begin
        safe_ff <= 1'b1;
      end else if (safe_exit_i) begin
        safe_ff <= 1'b0;
      end
    end
  end

  // error count wraps at 15 like the plain 4-bit counter it is
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      err_cnt_ff <= 4'h0;
    end else if (diag_trip || other_safe_entry_i) begin
      err_cnt_ff <= err_cnt_ff + 4'h1;
    end
  end

  // enable drive follows its command unless safe; a mismatch alone leaves it
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      drive_ff <= 1'b0;
    end else begin
      drive_ff <= enable_drive_cmd_i && !safe_ff && !diag_trip;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign nvm_check_trigger_o  = nvm_trig_ff;
  assign nvm_error_flag_o     = nvm_err_ff;
  assign safe_req_o           = safe_req_ff;
  assign enable_drive_out_o   = drive_ff;
  assign device_error_count_o = err_cnt_ff;
  assign lock_o               = lock_ff;
  assign cfg_check_en_o       = cfg_en_ff;
  assign cfg_busy_o           = (cfg_state_ff == CFG_RUN);
  assign cfg_mismatch_o       = mismatch_ff;
  assign stored_sig_o         = sig_ff;
  assign calc_sig_o           = calc_ff;
  assign prot_word_o          = prot_word;
endmodule
`default_nettype wire

// [rtl/crg_pkg.sv]
// constants shared by the configuration crc guard and its crc engine
// assumes a single 20 MHz system clock and an spi decoder on the same clock
package crg_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 50;
  // cfg check must finish within this time after the enabling write
  localparam int unsigned CFG_CRC_TIME_NS = 2100;
  localparam int unsigned CFG_CRC_CYCLES  = CFG_CRC_TIME_NS / CLK_PERIOD_NS;
  // longest nvm check time, microseconds
  localparam int unsigned NVM_CRC_TIME_US = 811;
  localparam int unsigned NVM_CRC_CYCLES  = (NVM_CRC_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned WORD_W  = 64;
  localparam int unsigned BYTES_N = 8;
  localparam logic [7:0]  CRC_POLY = 8'h07;
  localparam logic [7:0]  CRC_SEED = 8'hFF;

  // protected register indexes on the write port
  localparam logic [3:0] IDX_FUNC_CFG  = 4'h0;
  localparam logic [3:0] IDX_PWD_THR   = 4'h1;
  localparam logic [3:0] IDX_ERR_CFG   = 4'h2;
  localparam logic [3:0] IDX_TOKEN_FB  = 4'h3;
  localparam logic [3:0] IDX_WIN_B     = 4'h4;
  localparam logic [3:0] IDX_WIN_A     = 4'h5;
  localparam logic [3:0] IDX_LOW_PULSE = 4'h6;
  localparam logic [3:0] IDX_DEV_CFG_B = 4'h7;
  localparam logic [3:0] IDX_DEV_CFG_A = 4'h8;

  // reset values of the protected registers and the stored signature
  localparam logic [6:0] RST_FUNC_CFG  = 7'h00;
  localparam logic [3:0] RST_PWD_THR   = 4'h0;
  localparam logic [7:0] RST_ERR_CFG   = 8'h00;
  localparam logic [7:0] RST_TOKEN_FB  = 8'h00;
  localparam logic [4:0] RST_WIN_B     = 5'h00;
  localparam logic [6:0] RST_WIN_A     = 7'h00;
  localparam logic [7:0] RST_LOW_PULSE = 8'h00;
  localparam logic [7:0] RST_DEV_CFG_B = 8'h00;
  localparam logic [7:0] RST_DEV_CFG_A = 8'h00;
  localparam logic [7:0] RST_SIG       = 8'h00;

  // placement of fields in the protected word
  localparam int unsigned POS_FUNC_CFG  = 57;
  localparam int unsigned POS_REVISION  = 49;
  localparam int unsigned POS_PWD_THR   = 45;
  localparam int unsigned POS_ERR_CFG   = 37;
  localparam int unsigned POS_TOKEN_FB  = 29;
  localparam int unsigned POS_WIN_B     = 24;
  localparam int unsigned POS_WIN_A     = 17;
  localparam int unsigned POS_LOW_PULSE = 9;
  localparam int unsigned POS_DEV_CFG_B = 1;
  localparam int unsigned POS_DEV_CFG_A = 0;
  localparam int unsigned DEV_CFG_A_BIT = 6;

  typedef enum logic [0:0] {
    CFG_IDLE = 1'b0,
    CFG_RUN  = 1'b1
  } crg_cfg_state_e;

endpackage

// [tb/config_register_crc_guard_tb_top.sv]
// testbench for the config crc guard: lock, cfg check, nvm check, safe trip
// assumes the host model stands in for the nvm checker
`timescale 1ns/1ns
`default_nettype none
module config_register_crc_guard_tb_top;
  import crg_pkg::*;
  logic        clk, rstn, ewd, diag, drv;
  logic [7:0]  st, wd, rev, swd, ps;
  logic [3:0]  idx, ecnt, cnt;
  logic [63:0] word, ew;
  logic        nst, ntrig, nerr, sreq, dout, lck, cen, bsy, mis, ndone, ngood;
  logic [7:0]  ssig, csig, psig;
  int          failures, cmp_count;

  crg_guard #(.NVM_TIMEOUT_CYCLES(50)) i_crg_guard (.ref_clk_i(clk), .resetn_i(rstn),
    .prot_wr_i(st[0]), .prot_idx_i(idx), .prot_wdata_i(wd), .revision_i(rev), .lock_set_i(st[1]),
    .lock_clr_i(st[2]), .sig_wr_i(st[3]), .sig_wdata_i(swd), .cfg_en_wr_i(st[4]), .cfg_en_wdata_i(ewd),
    .nvm_trig_wr_i(st[5]), .nvm_done_i(ndone), .nvm_good_i(ngood), .nvm_start_o(nst),
    .nvm_check_trigger_o(ntrig), .nvm_error_flag_o(nerr), .diag_state_i(diag),
    .other_safe_entry_i(st[6]), .safe_exit_i(st[7]), .enable_drive_cmd_i(drv), .safe_req_o(sreq),
    .enable_drive_out_o(dout), .device_error_count_o(cnt), .lock_o(lck), .cfg_check_en_o(cen),
    .cfg_busy_o(bsy), .cfg_mismatch_o(mis), .stored_sig_o(ssig), .calc_sig_o(csig), .prot_word_o(word));
  crg_host_model i_crg_host_model (.ref_clk_i(clk), .resetn_i(rstn), .word_i(word), .start_i(nst),
    .sig_o(psig), .done_o(ndone), .good_o(ngood));

  //////////////////////////////////////////////////////////////////////////////
  // shared helpers: strobe pulse, settle, compare, close
  task automatic pul(input int k);
    @(posedge clk);
    st <= 8'h01 << k;
    @(posedge clk);
    st <= 8'h00;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim();
    $display("failures %0d compares %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    idx <= i;
    wd <= d;
    pul(0);
  endtask
  task automatic en(input logic v);
    ewd <= v;
    pul(4);
  endtask
  // store signature first, then 0 and 1 on enable; verdict checked twelve cycles on
  task automatic run(input logic [7:0] s);
    swd <= s;
    pul(3);
    en(1'b0);
    en(1'b1);
    wt(12);
    chk("busy", bsy, 0);
    chk("stored", ssig, s);
    chk("calc", csig, psig);
    chk("mismatch", mis, psig != s);
  endtask
  task automatic nvm(input logic e);
    pul(5);
    wt(2);
    chk("nvm run", {ntrig, nerr}, 2'b11);
    for (int i = 0; i < 100 && ntrig; i++) wt(1);
    chk("nvm trig", ntrig, 0);
    chk("nvm err", nerr, e);
  endtask
  // fill all nine fields; values differ per field
  task automatic fill(input logic [7:0] base);
    for (int i = 0; i < 9; i++) wr(4'(i), base + 8'(i * 29));
    wt(2);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // clock, watchdog, main sequence
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #(50 * 5000);
    failures++;
    end_sim();
  end
  initial begin
    {rstn, ewd, diag, st, wd, swd, idx, rev, ecnt} = '0;
    drv = 1'b1;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    wt(2);
    chk("zero word", word, 64'h0);
    chk("zero sig", psig, 8'hDB);
    run(8'hDB);
    rev <= 8'hFF;
    fill(8'hFF - 8'(8 * 29));
    for (int i = 0; i < 9; i++) wr(4'(i), 8'hFF);
    wt(2);
    chk("ones word", word, 64'hFFFF_FFFF_FFFF_FFFF);
    run(8'h0C);
    chk("ones sig", csig, 8'h0C);
    rev <= 8'h5A;
    fill(8'hC3);
    ew = {7'h43, 8'h5A, 4'h0, 8'hFD, 8'h1A, 5'h17, 7'h54, 8'h71, 8'h8E, 1'b0};
    chk("placed word", word, ew);
    ps = ~psig;
    run(ps);
    chk("drive kept", {dout, sreq}, 2'b10);
    wt(40);
    chk("mismatch held", mis, 1);
    nvm(1'b0);
    chk("mismatch cleared", mis, 0);
    pul(1);
    wr(4'h0, 8'h00);
    wt(2);
    chk("locked word", word, ew);
    pul(6);
    ecnt++;
    wt(2);
    chk("count other", cnt, ecnt);
    chk("lock kept", lck, 1);
    pul(2);
    wr(4'h0, 8'h00);
    wt(2);
    chk("unlocked word", word[63:57], 0);
    ps = ~psig;
    run(ps);
    en(1'b0);
    wt(1);
    chk("no trip", {sreq, dout}, 2'b01);
    nvm(1'b1);
    ps = ~psig;
    run(ps);
    diag <= 1'b1;
    en(1'b0);
    // safe request stands one cycle only, so look in the first half cycle
    wt(1);
    ecnt++;
    chk("trip", {sreq, dout, nerr, cen}, 4'b1010);
    chk("count trip", cnt, ecnt);
    wt(3);
    chk("drive held", dout, 0);
    pul(7);
    wt(3);
    chk("drive back", dout, 1);
    end_sim();
  end
endmodule
`default_nettype wire

// [tb/crg_guard_checker.sv]
// port-level timing checks for the config crc guard
// assumes one clock domain and an async active-low reset
`timescale 1ns/1ns
`default_nettype none
module crg_guard_checker (
  input wire logic        ref_clk_i,
  input wire logic        resetn_i,
  input wire logic        prot_wr_i,
  input wire logic        lock_clr_i,
  input wire logic        cfg_en_wr_i,
  input wire logic        cfg_en_wdata_i,
  input wire logic        diag_state_i,
  input wire logic        other_safe_entry_i,
  input wire logic        nvm_trig_wr_i,
  input wire logic        nvm_done_i,
  input wire logic        lock_o,
  input wire logic [63:0] prot_word_o,
  input wire logic        cfg_check_en_o,
  input wire logic        cfg_busy_o,
  input wire logic        cfg_mismatch_o,
  input wire logic [7:0]  calc_sig_o,
  input wire logic [7:0]  stored_sig_o,
  input wire logic        safe_req_o,
  input wire logic        enable_drive_out_o,
  input wire logic        nvm_error_flag_o,
  input wire logic [3:0]  device_error_count_o,
  input wire logic        nvm_check_trigger_o,
  input wire logic        nvm_start_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  //////////////////////////////////////////////////////////////////////////////
  // lock and protected word
  lock_kept_a: assert property (lock_o && !lock_clr_i |=> lock_o)
    else $error("lock dropped without a clear");
  locked_write_a: assert property (prot_wr_i && lock_o |=> $stable(prot_word_o))
    else $error("protected word changed while locked");
  // cfg check: busy for exactly nine cycles, then the verdict
  cfg_run_a: assert property (cfg_en_wr_i && cfg_en_wdata_i && !cfg_check_en_o
    |=> cfg_busy_o [*8] ##1 cfg_busy_o ##1 !cfg_busy_o) else $error("cfg check length wrong");
  cfg_verdict_a: assert property ($fell(cfg_busy_o) && cfg_check_en_o
    |-> cfg_mismatch_o == (calc_sig_o != stored_sig_o)) else $error("mismatch flag wrong");
  mismatch_quiet_a: assert property ($rose(cfg_mismatch_o)
    |-> !safe_req_o && $stable(enable_drive_out_o)) else $error("mismatch disturbed state");
  // diag trip when enable dropped with a pending mismatch
  diag_trip_a: assert property (cfg_en_wr_i && !cfg_en_wdata_i && cfg_check_en_o
    && cfg_mismatch_o && diag_state_i |=> safe_req_o && !enable_drive_out_o
    && nvm_error_flag_o && !cfg_check_en_o) else $error("diag trip missing");
  err_count_a: assert property (safe_req_o || $past(other_safe_entry_i)
    |-> device_error_count_o == $past(device_error_count_o) + 4'h1) else $error("count not bumped");
  // nvm check start and self-clear
  nvm_start_a: assert property (nvm_trig_wr_i && !nvm_check_trigger_o
    |=> nvm_start_o && nvm_check_trigger_o && nvm_error_flag_o) else $error("nvm start wrong");
  nvm_clear_a: assert property (nvm_done_i && nvm_check_trigger_o |=> !nvm_check_trigger_o)
    else $error("nvm trigger stuck");
endmodule

bind crg_guard crg_guard_checker i_crg_guard_checker (.ref_clk_i, .resetn_i, .prot_wr_i,
  .lock_clr_i, .cfg_en_wr_i, .cfg_en_wdata_i, .diag_state_i, .other_safe_entry_i, .nvm_trig_wr_i,
  .nvm_done_i, .lock_o, .prot_word_o, .cfg_check_en_o, .cfg_busy_o, .cfg_mismatch_o, .calc_sig_o,
  .stored_sig_o, .safe_req_o, .enable_drive_out_o, .nvm_error_flag_o, .device_error_count_o,
  .nvm_check_trigger_o, .nvm_start_o);
`default_nettype wire

// [tb/crg_host_model.sv]
// host side stand-in: signature maker and nvm checker responder
// assumes the guard's clock; nvm contents always good
`timescale 1ns/1ns
`default_nettype none
module crg_host_model #(
  parameter int unsigned DLY = 20
) (
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic [63:0] word_i,
  input  wire logic        start_i,
  output logic [7:0]       sig_o,
  output logic             done_o,
  output logic             good_o
);
  int unsigned cnt_ff;

  //////////////////////////////////////////////////////////////////////////////
  // signature: bytes lowest first, msb first, seed chained
  always_comb begin
    sig_o = 8'hFF;
    for (int b = 0; b < 8; b++) begin
      sig_o = sig_o ^ word_i[b*8 +: 8];
      for (int k = 0; k < 8; k++) begin
        sig_o = sig_o[7] ? ({sig_o[6:0], 1'b0} ^ 8'h07) : {sig_o[6:0], 1'b0};
      end
    end
  end
  // fixed delay answer, well inside the device timeout
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_ff <= 0;
      done_o <= 1'b0;
    end else begin
      done_o <= (cnt_ff == 1);
      if (start_i) cnt_ff <= DLY;
      else if (cnt_ff != 0) cnt_ff <= cnt_ff - 1;
    end
  end
  // good only counts with done; wobbles otherwise so nothing leans on it
  assign good_o = done_o | cnt_ff[0];
endmodule
`default_nettype wire
